// ===== hw/cfs_loader.sv
// Configuration set loader with AXI4-Lite register access
// Behaviour
// RULE1: The active set lives in flops that reset clears, so it is lost at every reset.
// RULE2: The factory set is fixed logic in the store and no write can change it.
// RULE3: There are exactly three user slots, numbered 1 to 3, in the store.
// RULE4: User slot contents sit in unreset storage and survive reset.
// RULE5: Software must pick user slot 1, 2 or 3 before a store; the factory set is no target.
// RULE6: A store copies the savable words of the active set into the chosen slot.
// RULE7: A store rewrites every savable word of the slot, keeping nothing old.
// RULE8: Transmission delay, packet delay and lookup table words are never stored.
// RULE9: A restore overwrites the active set with the chosen slot or the factory set.
// RULE10: A restore is allowed only while acquisition is neither running nor pending.
// RULE11: Software chooses the boot set from user slot 1, 2, 3 or the factory set.
// RULE12: After every reset the boot set is copied into the active set before operation.
// RULE13: A restore during running or pending acquisition is ignored and the set kept.
`timescale 1ns/1ps
`default_nettype none
module cfs_loader
    import cfs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic acq_running,
    input wire logic acq_pending,
    output logic [NUM_WORDS-1:0][31:0] active_set,
    output logic set_busy
);
    cfs_mem_if mem ();

    cfs_nv_store u_store (
        .aclk(aclk),
        .mem(mem)
    );

    cfs_state_t state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [NUM_WORDS-1:0][31:0] active_q, active_d;
    logic [1:0] slot_q, slot_d;
    logic [1:0] boot_sel_q, boot_sel_d;
    logic [1:0] src_q, src_d;
    logic refused_q, refused_d;
    logic busy_q, busy_d;
    logic aw_have_q, aw_have_d;
    logic [AXI_AW-1:0] awaddr_q, awaddr_d;
    logic w_have_q, w_have_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic mem_we;
    logic [MEM_AW-1:0] mem_addr;
    logic [31:0] mem_wdata;

    assign mem.we = mem_we;
    assign mem.addr = mem_addr;
    assign mem.wdata = mem_wdata;

    always_comb begin
        logic [2:0] widx;
        logic idle_acq;
        widx = 3'h0;
        idle_acq = !acq_running && !acq_pending;
        state_d = state_q;
        cnt_d = cnt_q;
        active_d = active_q;
        slot_d = slot_q;
        boot_sel_d = boot_sel_q;
        src_d = src_q;
        refused_d = refused_q;
        aw_have_d = aw_have_q;
        awaddr_d = awaddr_q;
        w_have_d = w_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        mem_we = 1'b0;
        mem_addr = cfs_mem_addr(src_q, cnt_q);
        mem_wdata = active_q[cnt_q];

        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end

        // Reads are answered one cycle after the address is taken
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = 32'h0000_0000;
            if (s_axi_araddr[1:0] != 2'h0) begin
                rresp_d = RESP_SLVERR;
            end else if (s_axi_araddr >= REG_ACTIVE_BASE && s_axi_araddr <= REG_ACTIVE_LAST) begin
                rdata_d = active_q[s_axi_araddr[4:2]];
            end else begin
                case (s_axi_araddr)
                    REG_CTRL: rdata_d = 32'h0000_0000;
                    REG_SLOT_SEL: rdata_d = {30'h0, slot_q};
                    REG_BOOT_SEL: rdata_d = {30'h0, boot_sel_q};
                    REG_STATUS: rdata_d = {28'h0, src_q, refused_q, busy_q};
                    default: rresp_d = RESP_SLVERR;
                endcase
            end
        end

        unique case (state_q)
            ST_BOOT_RD: begin
                mem_addr = BOOT_ADDR;
                state_d = ST_BOOT_WT;
            end
            ST_BOOT_WT: begin
                // Unknown or fresh storage falls back to the factory set
                case (mem.rdata[1:0])
                    SET_USER1: src_d = SET_USER1;
                    SET_USER2: src_d = SET_USER2;
                    SET_USER3: src_d = SET_USER3;
                    default: src_d = SET_FACTORY;
                endcase
                boot_sel_d = src_d;
                cnt_d = 3'h0;
                state_d = ST_LOAD; // RULE12
            end
            ST_LOAD: begin
                // Store data lag the address by one cycle
                if (cnt_q != 3'h0) begin
                    widx = 3'(cnt_q - 3'h1);
                    active_d[widx] = mem.rdata; // RULE9
                end
                if (cnt_q == 3'(SAVE_WORDS)) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = 3'(cnt_q + 3'h1);
                end
            end
            ST_STORE: begin
                // Every savable word is written, the rest never
                mem_we = 1'b1; // RULE6
                mem_addr = cfs_mem_addr(slot_q, cnt_q); // RULE7 RULE8
                if (cnt_q == 3'(SAVE_WORDS - 1)) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = 3'(cnt_q + 3'h1);
                end
            end
            ST_IDLE: begin
                // Writes wait here so a command never lands mid-copy
                if (aw_have_q && w_have_q && !bvalid_q) begin
                    aw_have_d = 1'b0;
                    w_have_d = 1'b0;
                    bvalid_d = 1'b1;
                    bresp_d = RESP_OKAY;
                    if (awaddr_q[1:0] != 2'h0) begin
                        bresp_d = RESP_SLVERR;
                    end else if (awaddr_q >= REG_ACTIVE_BASE && awaddr_q <= REG_ACTIVE_LAST) begin
                        for (int b = 0; b < 4; b++) begin
                            if (wstrb_q[b]) begin
                                active_d[awaddr_q[4:2]][b*8 +: 8] = wdata_q[b*8 +: 8];
                            end
                        end
                    end else begin
                        case (awaddr_q)
                            REG_CTRL: begin
                                if (wstrb_q[0]) begin
                                    if (wdata_q[CTRL_CLR_BIT]) begin
                                        refused_d = 1'b0;
                                    end
                                    if (wdata_q[CTRL_RESTORE_BIT]) begin
                                        if (idle_acq) begin
                                            src_d = slot_q;
                                            cnt_d = 3'h0;
                                            state_d = ST_LOAD; // RULE10
                                        end else begin
                                            refused_d = 1'b1; // RULE13
                                        end
                                    end else if (wdata_q[CTRL_STORE_BIT]) begin
                                        if (slot_q != SET_FACTORY) begin
                                            cnt_d = 3'h0;
                                            state_d = ST_STORE; // RULE5
                                        end else begin
                                            refused_d = 1'b1; // RULE2
                                        end
                                    end
                                end
                            end
                            REG_SLOT_SEL: begin
                                if (wstrb_q[0]) begin
                                    slot_d = wdata_q[1:0]; // RULE3
                                end
                            end
                            REG_BOOT_SEL: begin
                                if (wstrb_q[0]) begin
                                    boot_sel_d = wdata_q[1:0]; // RULE11
                                    mem_we = 1'b1;
                                    mem_addr = BOOT_ADDR;
                                    mem_wdata = {30'h0, wdata_q[1:0]};
                                end
                            end
                            REG_STATUS: ;
                            default: bresp_d = RESP_SLVERR;
                        endcase
                    end
                end
            end
        endcase

        busy_d = (state_d != ST_IDLE);
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_BOOT_RD; // RULE12
            cnt_q <= 3'h0;
            active_q <= {NUM_WORDS{ACTIVE_RST}}; // RULE1 RULE8
            slot_q <= SET_USER1;
            boot_sel_q <= SET_FACTORY;
            src_q <= SET_FACTORY;
            refused_q <= 1'b0;
            busy_q <= 1'b1;
            aw_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            w_have_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            active_q <= active_d;
            slot_q <= slot_d;
            boot_sel_q <= boot_sel_d;
            src_q <= src_d;
            refused_q <= refused_d;
            busy_q <= busy_d;
            aw_have_q <= aw_have_d;
            awaddr_q <= awaddr_d;
            w_have_q <= w_have_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign active_set = active_q;
    assign set_busy = busy_q;
endmodule
`default_nettype wire

// ===== hw/cfs_mem_if.sv
// Port between the loader core and its non-volatile set store
`timescale 1ns/1ps
`default_nettype none
interface cfs_mem_if;
    import cfs_pkg::*;
    logic we;
    logic [MEM_AW-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport host (output we, output addr, output wdata, input rdata);
    modport store (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== hw/cfs_nv_store.sv
// Non-volatile set store: factory set, three user slots, boot choice
`timescale 1ns/1ps
`default_nettype none
module cfs_nv_store
    import cfs_pkg::*;
(
    input wire logic aclk,
    cfs_mem_if.store mem
);
    // No reset on purpose: contents must outlive aresetn
    logic [31:0] cells [MEM_DEPTH];
    logic [31:0] rdata_q;
    logic is_factory;

    assign is_factory = (mem.addr[4:3] == SET_FACTORY) && (mem.addr != BOOT_ADDR); // RULE2

    always_ff @(posedge aclk) begin
        if (mem.we && !is_factory) begin
            cells[mem.addr] <= mem.wdata; // RULE4
        end
        rdata_q <= is_factory ? FACTORY_SET[mem.addr[2:0]] : cells[mem.addr];
    end

    assign mem.rdata = rdata_q;
endmodule
`default_nettype wire

// ===== hw/cfs_pkg.sv
// Constants and types shared by the configuration set loader
package cfs_pkg;
    localparam int AXI_AW = 8;
    localparam int NUM_WORDS = 8;
    localparam int SAVE_WORDS = 6;
    localparam int MEM_AW = 5;
    localparam int MEM_DEPTH = 32;

    localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] REG_SLOT_SEL = 8'h04;
    localparam logic [AXI_AW-1:0] REG_BOOT_SEL = 8'h08;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h0C;
    localparam logic [AXI_AW-1:0] REG_ACTIVE_BASE = 8'h20;
    localparam logic [AXI_AW-1:0] REG_ACTIVE_LAST = 8'h3C;

    localparam int CTRL_STORE_BIT = 0;
    localparam int CTRL_RESTORE_BIT = 1;
    localparam int CTRL_CLR_BIT = 2;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REFUSED_BIT = 1;
    localparam int STAT_SRC_LSB = 2;

    localparam logic [1:0] SET_FACTORY = 2'h0;
    localparam logic [1:0] SET_USER1 = 2'h1;
    localparam logic [1:0] SET_USER2 = 2'h2;
    localparam logic [1:0] SET_USER3 = 2'h3;
    localparam logic [MEM_AW-1:0] BOOT_ADDR = 5'h07;
    localparam logic [31:0] ACTIVE_RST = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Factory values, fixed in the logic so no write path can reach them
    localparam logic [NUM_WORDS-1:0][31:0] FACTORY_SET = {
        32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 32'h0000_0010,
        32'h0000_0020, 32'h0000_0000, 32'h0000_0040, 32'h0000_1000
    };

    typedef enum logic [4:0] {
        ST_BOOT_RD = 5'b00001,
        ST_BOOT_WT = 5'b00010,
        ST_IDLE = 5'b00100,
        ST_LOAD = 5'b01000,
        ST_STORE = 5'b10000
    } cfs_state_t;

    function automatic logic [MEM_AW-1:0] cfs_mem_addr(input logic [1:0] set,
                                                       input logic [2:0] word);
        return {set, word};
    endfunction
endpackage

// ===== tb/cfs_loader_monitor.sv
// Port-level assertions for the configuration set loader
`timescale 1ns/1ps
`default_nettype none
module cfs_loader_monitor
    import cfs_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_WORDS-1:0][31:0] active_set,
    input wire logic set_busy
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_reset_clears: assert property ($rose(aresetn) |-> set_busy && active_set == '0)
        else $error("active set not cleared or not busy after reset");
    chk_boot_ends: assert property ($rose(aresetn) |-> ##[1:12] !set_busy)
        else $error("boot load too long");
    chk_load_ends: assert property ($rose(set_busy) |-> ##[1:10] !set_busy)
        else $error("load or store too long");
    chk_nosave_kept: assert property (set_busy ##1 set_busy |-> $stable(active_set[7:6]))
        else $error("non-savable words changed by a load");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_wr_gate: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
endmodule
`default_nettype wire

// ===== tb/tb_config_set_store_loader.sv
// Self-checking bench for the configuration set loader
`timescale 1ns/1ps
`default_nettype none
module tb_config_set_store_loader;
    import cfs_pkg::*;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic acq_running, acq_pending, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, set_busy;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [NUM_WORDS-1:0][31:0] active_set;
    logic [33:0] exp_q[$];
    logic [31:0] act[8];
    logic [31:0] slot[4][8];
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 53;
    cfs_loader cfs_loader_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acq_running, .acq_pending, .active_set,
        .set_busy);
    always #10 aclk = ~aclk;
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Responses arrive in request order, one bus user at a time
    always @(posedge aclk) begin
        cycles++;
        if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, exp_q.pop_front());
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({r, 32'h0});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= (a >= REG_ACTIVE_BASE) ? 4'hF : 4'h1;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    // Store and restore start in the cycle the response is raised; wait a few cycles before polling busy
    task automatic wait_idle();
        repeat (3) @(posedge aclk);
        while (set_busy) @(posedge aclk);
    endtask
    task automatic act_chk();
        for (int i = 0; i < 8; i++) rd(REG_ACTIVE_BASE + 8'(i * 4), {RESP_OKAY, act[i]});
    endtask
    task automatic fill();
        for (int i = 0; i < 8; i++) begin
            act[i] = $random(seed);
            wr(REG_ACTIVE_BASE + 8'(i * 4), act[i], RESP_OKAY);
        end
    endtask
    task automatic cmd(input logic [1:0] s, input logic [31:0] c);
        wr(REG_SLOT_SEL, {30'h0, s}, RESP_OKAY);
        wr(REG_CTRL, c, RESP_OKAY);
        wait_idle();
        if (c == 32'h2 && !acq_running && !acq_pending) begin
            for (int i = 0; i < SAVE_WORDS; i++) act[i] = slot[s][i];
        end
        if (c == 32'h1 && s != SET_FACTORY) begin
            for (int i = 0; i < SAVE_WORDS; i++) slot[s][i] = act[i];
        end
    endtask
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        wait_idle();
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, acq_running, acq_pending, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, s_axi_wstrb} = '0;
        for (int i = 0; i < 8; i++) slot[0][i] = FACTORY_SET[i];
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        wait_idle();
        for (int i = 0; i < 8; i++) act[i] = FACTORY_SET[i];
        act_chk();
        rd(REG_STATUS, {RESP_OKAY, 32'h0});
        for (int k = 1; k < 4; k++) begin
            fill();
            cmd(2'(k), 32'h1);
        end
        fill();
        cmd(SET_USER1, 32'h1);
        for (int k = 3; k >= 0; k--) begin
            fill();
            cmd(2'(k), 32'h2);
            act_chk();
            rd(REG_STATUS, {RESP_OKAY, 28'h0, 2'(k), 2'b00});
        end
        // Both acquisition states must block a restore
        acq_running <= 1'b1;
        cmd(SET_USER2, 32'h2);
        acq_running <= 1'b0;
        acq_pending <= 1'b1;
        cmd(SET_USER1, 32'h2);
        act_chk();
        rd(REG_STATUS, {RESP_OKAY, 32'h2});
        acq_pending <= 1'b0;
        wr(REG_CTRL, 32'h4, RESP_OKAY);
        cmd(SET_FACTORY, 32'h1);
        rd(REG_STATUS, {RESP_OKAY, 32'h2});
        wr(REG_CTRL, 32'h4, RESP_OKAY);
        wr(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
        rd(8'h10, {RESP_SLVERR, 32'h0});
        rd(8'h22, {RESP_SLVERR, 32'h0});
        wr(REG_BOOT_SEL, {30'h0, SET_USER2}, RESP_OKAY);
        fill();
        do_reset();
        for (int i = 0; i < 8; i++) act[i] = (i < SAVE_WORDS) ? slot[2][i] : 32'h0;
        act_chk();
        rd(REG_STATUS, {RESP_OKAY, 32'h8});
        rd(REG_SLOT_SEL, {RESP_OKAY, 32'h1});
        rd(REG_BOOT_SEL, {RESP_OKAY, 30'h0, SET_USER2});
        cmd(SET_USER3, 32'h2);
        act_chk();
        report_and_stop();
    end
endmodule
bind cfs_loader cfs_loader_monitor cfs_loader_monitor_i (.aclk, .aresetn, .s_axi_awready,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .active_set, .set_busy);
`default_nettype wire
